/* File: logic/adc_i2c_command_sequencer.v */
// Purpose: I2C target command interpreter and conversion sequencer.
// Assumes: Byte-level I2C front end; events are one-cycle pulses.
// Notes: Pins are taken as synchronous to clk.
//
// What this block does
// - At power-up latch target address from strap and set brownout flag.
// - Reset on general call 00h then 06h, reset bit, or power cycle.
// - Manual mode takes channel from register; host starts conversions.
// - Start conversion on ack edge of last output data byte.
// - Auto mode steps to next enabled channel, ascending, after conversion.
// - Run bit one enables sequencing; zero stops channel selection.
// - Opcode 10h single read, 30h block read.
// - Opcode 08h single write, 28h block write.
// - Single read: three-frame address command, then read frame returns data.
// - Single read repeats same register for extra bytes.
// - Block read returns next register per further byte.
// - Unimplemented or past-end addresses read as zero.
// - Set-bit opcode 18h sets bits where mask is one.
// - Clear-bit opcode 20h clears bits where mask is one.
// - Block write bytes to unimplemented addresses have no effect.
// - Block write bytes past address space are discarded.
// - Power up in manual mode; mode changes only by register write or reset.
// - Mode field 00b manual, 01b auto-sequence.
// - Acknowledge general call address 00h.
// - High-speed master code sets flag until stop condition.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"
module adc_i2c_command_sequencer (
    input wire clk,
    input wire rst_n,
    input wire [2:0] addr_strap,
    input wire bus_start,
    input wire bus_stop,
    input wire addr_valid,
    input wire [7:0] addr_byte,
    input wire rx_valid,
    input wire [7:0] rx_byte,
    input wire tx_ack_edge,
    input wire conv_done,
    output reg addr_ack,
    output reg [7:0] tx_byte,
    output reg [6:0] target_addr,
    output reg conv_start,
    output reg [2:0] mux_channel,
    output reg [7:0] status_reg,
    output reg high_speed,
    output reg sequencer_active
);
    // Command phases.
    localparam PH_IDLE = 2'h0;
    localparam PH_OPCODE = 2'h1;
    localparam PH_ADDR = 2'h2;
    localparam PH_DATA = 2'h3;

    // Frame tracking, command and configuration state.
    reg [1:0] phase;
    reg [7:0] opcode;
    reg [7:0] ptr;
    reg rd_single;
    reg gc_frame;
    reg addressed_rd;
    reg addr_known;
    reg [1:0] frame_cnt;
    reg soft_rst;
    reg brownout_reset_flag;
    reg [7:0] general_cfg;
    reg [1:0] conversion_mode_select;
    reg sequencer_run_bit;
    reg [2:0] manual_channel_select;
    reg [7:0] sequence_channel_enables;
    wire [2:0] seq_next;

    // Read mux; unmapped addresses read zero.
    function [7:0] reg_read;
        input [7:0] a;
        begin
            if (a == `REG_STATUS) begin
                reg_read = status_reg;
            end else if (a == `REG_GENERAL) begin
                reg_read = general_cfg;
            end else if (a == `REG_OPMODE) begin
                reg_read = {6'h00, conversion_mode_select};
            end else if (a == `REG_SEQ_CFG) begin
                reg_read = {3'h0, sequencer_run_bit, 4'h0};
            end else if (a == `REG_CHAN_SEL) begin
                reg_read = {5'h00, manual_channel_select};
            end else if (a == `REG_SEQ_EN) begin
                reg_read = sequence_channel_enables;
            end else begin
                // Gaps and addresses past the last register.
                reg_read = 8'h00;
            end
        end
    endfunction

    // Ascending search for the next enabled channel, with wrap.
    next_channel_pick u_pick (
        .current(mux_channel),
        .enables(sequence_channel_enables),
        .next_chan(seq_next)
    );

    // Opcode and mode decodes shared by the processes below.
    wire auto_mode = (conversion_mode_select == `MODE_AUTO);
    wire [7:0] cur_val = reg_read(ptr);
    wire is_write_op = (opcode == `OP_WR_SINGLE) ||
        (opcode == `OP_WR_BLOCK) || (opcode == `OP_SET_BITS) ||
        (opcode == `OP_CLR_BITS);
    wire is_block = (opcode == `OP_WR_BLOCK);
    wire data_wr = rx_valid && (phase == PH_DATA) && !gc_frame &&
        is_write_op;
    // Set and clear compose the new value from the mask.
    wire [7:0] wr_val = (opcode == `OP_SET_BITS) ? (cur_val | rx_byte) :
        (opcode == `OP_CLR_BITS) ? (cur_val & ~rx_byte) : rx_byte;
    // Write-one-to-clear bits see the mask byte, or zero for a clear-bit opcode,
    // so a set or clear aimed at other status bits leaves the brownout flag alone.
    wire [7:0] w1c_val = (opcode == `OP_CLR_BITS) ? 8'h00 : rx_byte;
    // Only the reset byte inside a general call frame acts.
    wire gc_reset = rx_valid && gc_frame && (rx_byte == `GC_RESET);
    // The mask accepts each of the four high-speed master codes.
    wire hs_code = addr_valid &&
        ((addr_byte & `HS_CODE_MASK) == `HS_CODE_VAL);

    // Address match, general call and frame phase tracking.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase <= PH_IDLE;
            opcode <= 8'h00;
            ptr <= 8'h00;
            rd_single <= 1'b0;
            gc_frame <= 1'b0;
            addressed_rd <= 1'b0;
            addr_ack <= 1'b0;
            high_speed <= 1'b0;
            tx_byte <= 8'h00;
        end else begin
            addr_ack <= 1'b0;
            // A stop closes the frame and drops high speed.
            if (bus_stop) begin
                phase <= PH_IDLE;
                gc_frame <= 1'b0;
                addressed_rd <= 1'b0;
                high_speed <= 1'b0;
            end else if (hs_code) begin
                high_speed <= 1'b1;
            end else if (addr_valid) begin
                if (addr_byte[7:1] == `GC_ADDR && !addr_byte[0]) begin
                    addr_ack <= 1'b1;
                    gc_frame <= 1'b1;
                    phase <= PH_DATA;
                end else if (addr_byte[7:1] == target_addr) begin
                    addr_ack <= 1'b1;
                    gc_frame <= 1'b0;
                    addressed_rd <= addr_byte[0];
                    phase <= addr_byte[0] ? PH_IDLE : PH_OPCODE;
                    tx_byte <= cur_val;
                end else begin
                    phase <= PH_IDLE;
                    addressed_rd <= 1'b0;
                end
            end else if (bus_start) begin
                // A repeated start waits for its address byte.
                phase <= PH_IDLE;
            end else if (rx_valid && !gc_frame) begin
                if (phase == PH_OPCODE) begin
                    opcode <= rx_byte;
                    rd_single <= (rx_byte == `OP_RD_SINGLE);
                    phase <= PH_ADDR;
                end else if (phase == PH_ADDR) begin
                    ptr <= rx_byte;
                    phase <= PH_DATA;
                end else if (phase == PH_DATA && is_write_op) begin
                    // On writes the pointer parks at the top, so it does not wrap here.
                    // pointer steps per byte
                    if (is_block && ptr != `PTR_MAX) begin
                        ptr <= ptr + 8'h01;
                    end
                end
            end else if (tx_ack_edge && addressed_rd) begin
                // The byte for the following clocks is staged here.
                // single read repeats data
                if (!rd_single) begin
                    tx_byte <= reg_read(ptr + 8'h01);
                    ptr <= ptr + 8'h01;
                end else begin
                    tx_byte <= cur_val;
                end
            end
        end
    end

    // Configuration registers and reset sources.
    // A soft reset lands one cycle after its request, so the frame
    // that carried it still completes cleanly.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            brownout_reset_flag <= 1'b1;
            conversion_mode_select <= `MODE_MANUAL;
            general_cfg <= 8'h00;
            sequencer_run_bit <= 1'b0;
            manual_channel_select <= 3'h0;
            sequence_channel_enables <= 8'h00;
            soft_rst <= 1'b0;
        end else if (soft_rst) begin
            brownout_reset_flag <= 1'b1;
            conversion_mode_select <= `MODE_MANUAL;
            general_cfg <= 8'h00;
            sequencer_run_bit <= 1'b0;
            manual_channel_select <= 3'h0;
            sequence_channel_enables <= 8'h00;
            soft_rst <= 1'b0;
        end else begin
            if (gc_reset) begin
                soft_rst <= 1'b1;
            end
            if (data_wr && (is_block || frame_cnt == 2'h0)) begin
                if (ptr == `REG_STATUS) begin
                    // The brownout flag clears only on a written one.
                    if (w1c_val[`STATUS_BOR_BIT] == 1'b1) begin
                        brownout_reset_flag <= 1'b0;
                    end
                end else if (ptr == `REG_GENERAL) begin
                    general_cfg <= wr_val;
                    if (wr_val[`GENERAL_RST_BIT]) begin
                        soft_rst <= 1'b1;
                    end
                end else if (ptr == `REG_OPMODE) begin
                    conversion_mode_select <= wr_val[1:0];
                end else if (ptr == `REG_SEQ_CFG) begin
                    sequencer_run_bit <= wr_val[`SEQ_RUN_BIT];
                end else if (ptr == `REG_CHAN_SEL) begin
                    manual_channel_select <= wr_val[2:0];
                end else if (ptr == `REG_SEQ_EN) begin
                    sequence_channel_enables <= wr_val;
                end
            end
        end
    end

    // Counts data bytes of one write command for single-byte forms.
    // It saturates, so later bytes of a single write are never stored.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_cnt <= 2'h0;
        end else if (bus_start || bus_stop || addr_valid) begin
            frame_cnt <= 2'h0;
        end else if (data_wr && frame_cnt != `FRAME_CNT_MAX) begin
            frame_cnt <= frame_cnt + 2'h1;
        end
    end

    // Latches the strapped address once after reset release.
    // Later changes on the strap pin are ignored until the next reset.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_known <= 1'b0;
            target_addr <= `ADDR_BASE;
        end else if (!addr_known) begin
            addr_known <= 1'b1;
            target_addr <= `ADDR_BASE | {4'h0, addr_strap};
        end
    end

    // Conversion start and channel multiplexer control.
    // Register reads keep their opcode, so their bytes are never
    // counted as a conversion frame.
    reg [1:0] byte_cnt;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_start <= 1'b0;
            mux_channel <= 3'h0;
            sequencer_active <= 1'b0;
            byte_cnt <= 2'h0;
        end else begin
            conv_start <= 1'b0;
            sequencer_active <= auto_mode && sequencer_run_bit;
            if (addr_valid && addr_byte[7:1] == target_addr) begin
                byte_cnt <= 2'h0;
                if (addr_byte[0] && !(opcode == `OP_RD_SINGLE ||
                    opcode == `OP_RD_BLOCK) && !auto_mode) begin
                    mux_channel <= manual_channel_select;
                end
            end else if (tx_ack_edge && addressed_rd &&
                opcode != `OP_RD_SINGLE && opcode != `OP_RD_BLOCK) begin
                if (byte_cnt == `FRAME_BYTES - 2'h1) begin
                    byte_cnt <= 2'h0;
                    conv_start <= 1'b1;
                end else begin
                    byte_cnt <= byte_cnt + 2'h1;
                end
            end
            // Manual mode follows the channel register on every clock.
            if (!auto_mode) begin
                mux_channel <= manual_channel_select;
            end else if (conv_done && sequencer_run_bit) begin
                mux_channel <= seq_next;
            end
        end
    end

    // Status byte assembled from live state.
    // Status reads therefore lag the live state by one clock.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= `STATUS_RST;
        end else begin
            status_reg <= 8'h00;
            status_reg[`STATUS_RSVD_BIT] <= 1'b1;
            status_reg[`STATUS_SEQ_BIT] <= auto_mode && sequencer_run_bit;
            status_reg[`STATUS_HS_BIT] <= high_speed;
            status_reg[`STATUS_BOR_BIT] <= brownout_reset_flag;
        end
    end
endmodule
`default_nettype wire

/* File: logic/adc_seq_map.vh */
// Purpose: Named constants for the ADC command sequencer.
// Assumes: Included by bare name from the design files.
// Notes: Holds definitions only.
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
`define OP_RD_SINGLE 8'h10
`define OP_WR_SINGLE 8'h08
`define OP_SET_BITS 8'h18
`define OP_CLR_BITS 8'h20
`define OP_RD_BLOCK 8'h30
`define OP_WR_BLOCK 8'h28
`define GC_ADDR 7'h00
`define GC_RESET 8'h06
`define HS_CODE_MASK 8'hf9
`define HS_CODE_VAL 8'h09
`define REG_STATUS 8'h00
`define REG_GENERAL 8'h01
`define REG_OPMODE 8'h04
`define REG_SEQ_CFG 8'h10
`define REG_CHAN_SEL 8'h11
`define REG_SEQ_EN 8'h12
`define REG_LAST 8'h12
`define STATUS_RSVD_BIT 3'd7
`define STATUS_SEQ_BIT 3'd6
`define STATUS_HS_BIT 3'd5
`define STATUS_BOR_BIT 3'd0
`define GENERAL_RST_BIT 3'd0
`define SEQ_RUN_BIT 3'd4
`define MODE_LSB 3'd0
`define MODE_MANUAL 2'h0
`define MODE_AUTO 2'h1
`define ADDR_BASE 7'h10
`define ADDR_BITS 3
`define FRAME_BYTES 2'h2
`define FRAME_CNT_MAX 2'h3
`define PTR_MAX 8'hff
`define STATUS_RST 8'h81
`endif

/* File: logic/next_channel_pick.v */
// Purpose: Picks the next enabled channel above the current one.
// Assumes: Eight channels; search wraps to channel zero.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module next_channel_pick (
    input wire [2:0] current,
    input wire [7:0] enables,
    output reg [2:0] next_chan
);
    integer i;
    reg [2:0] idx;
    reg found;

    // Scan ascending from current plus one, wrapping around.
    always @* begin
        next_chan = current;
        found = 1'b0;
        idx = 3'h0;
        for (i = 1; i <= 8; i = i + 1) begin
            idx = current + i[2:0];
            if (!found && enables[idx]) begin
                next_chan = idx;
                found = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/host_model.sv */
// Purpose: Byte-level bus host feeding the sequencer's event inputs.
// Assumes: One event per two clocks, as the front end reports them.
// Notes: A released byte lane shows the inverse of its last value.
`timescale 1ns/1ps
`default_nettype none
module host_model #(
    parameter logic [6:0] DEV = 7'h15
) (
    input wire logic clk,
    input wire logic addr_ack,
    input wire logic conv_start,
    input wire logic [7:0] tx_byte,
    output logic bus_start,
    output logic bus_stop,
    output logic addr_valid,
    output logic [7:0] addr_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic tx_ack_edge
);
    logic got_ack = 1'b0;
    logic got_conv = 1'b0;
    // Idle levels at time zero.
    initial begin
        {tx_ack_edge, rx_valid, addr_valid, bus_stop, bus_start} = 5'h0;
        addr_byte = 8'h00;
        rx_byte = 8'h00;
    end
    // One event: 0 start, 1 stop, 2 address, 3 data in, 4 ack.
    task automatic ev(input int k, input logic [7:0] b);
        @(posedge clk);
        {tx_ack_edge, rx_valid, addr_valid, bus_stop, bus_start} <= 5'(1 << k);
        if (k == 2) addr_byte <= b;
        if (k == 3) rx_byte <= b;
        @(posedge clk);
        {tx_ack_edge, rx_valid, addr_valid, bus_stop, bus_start} <= 5'h0;
        addr_byte <= ~addr_byte;
        rx_byte <= ~rx_byte;
        #1;
        got_ack = addr_ack;
        got_conv = conv_start;
    endtask
    task automatic cmd(input logic [7:0] op, ra, d, input int n);
        ev(0, 8'h00);
        ev(2, {DEV, 1'b0});
        ev(3, op);
        ev(3, ra);
        for (int i = 0; i < n; i++) ev(3, d + 8'(i));
        ev(1, 8'h00);
    endtask
    task automatic rd_open();
        ev(0, 8'h00);
        ev(2, {DEV, 1'b1});
    endtask
    task automatic rd_byte(output logic [7:0] b);
        b = tx_byte;
        ev(4, 8'h00);
    endtask
endmodule
`default_nettype wire

/* File: sim/seq_properties.sv */
// Purpose: Port properties of the command sequencer.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Bound to the design top below the module.
`timescale 1ns/1ps
`default_nettype none
module seq_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] addr_strap,
    input wire logic bus_stop,
    input wire logic addr_valid,
    input wire logic [7:0] addr_byte,
    input wire logic rx_valid,
    input wire logic tx_ack_edge,
    input wire logic conv_done,
    input wire logic addr_ack,
    input wire logic [6:0] target_addr,
    input wire logic conv_start,
    input wire logic [2:0] mux_channel,
    input wire logic high_speed
);
    // Every check runs on clk and rests while reset is low.
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    property p_addr;
        $past(rst_n) |-> target_addr == {4'h2, addr_strap};
    endproperty
    a_addr: assert property (p_addr) else $error("bad address");
    property p_ack_own;
        addr_valid && addr_byte[7:1] == target_addr |=> addr_ack;
    endproperty
    a_ack_own: assert property (p_ack_own) else $error("no ack");
    property p_ack_gc;
        addr_valid && addr_byte == 8'h00 |=> addr_ack;
    endproperty
    a_ack_gc: assert property (p_ack_gc) else $error("no gc ack");
    property p_ack_why;
        addr_ack |-> $past(addr_valid) && (($past(addr_byte) & 8'hfe) ==
            {target_addr, 1'b0} || $past(addr_byte) == 8'h00);
    endproperty
    a_ack_why: assert property (p_ack_why) else $error("stray ack");
    property p_conv;
        conv_start |-> $past(tx_ack_edge) ##1 !conv_start;
    endproperty
    a_conv: assert property (p_conv) else $error("stray start");
    property p_hs_set;
        addr_valid && (addr_byte & 8'hf9) == 8'h09 |=> high_speed;
    endproperty
    a_hs_set: assert property (p_hs_set) else $error("no hs");
    property p_hs_hold;
        high_speed && !bus_stop |=> high_speed;
    endproperty
    a_hs_hold: assert property (p_hs_hold) else $error("hs lost");
    property p_hs_clr;
        bus_stop |=> !high_speed;
    endproperty
    a_hs_clr: assert property (p_hs_clr) else $error("hs held");
    property p_mux;
        $changed(mux_channel) |-> $past(conv_done) || $past(conv_done, 2)
            || $past(rx_valid) || $past(rx_valid, 2)
            || $past(rx_valid, 3) || $past(rx_valid, 4);
    endproperty
    a_mux: assert property (p_mux) else $error("mux moved");
    c_conv: cover property (conv_start);
    c_hs: cover property ($rose(high_speed));
    c_gc: cover property (addr_valid && addr_byte == 8'h00 ##1 addr_ack);
endmodule
bind adc_i2c_command_sequencer seq_props u_props (
    .clk, .rst_n, .addr_strap, .bus_stop, .addr_valid, .addr_byte,
    .rx_valid, .tx_ack_edge, .conv_done, .addr_ack, .target_addr,
    .conv_start, .mux_channel, .high_speed
);
`default_nettype wire

/* File: sim/tb.sv */
// Purpose: Self-checking bench for the command sequencer.
// Assumes: The host model issues every bus event.
// Notes: Strap 5 gives target address 15h.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_map.vh"
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] addr_strap = 3'h5;
    logic conv_done = 1'b0;
    logic bus_start, bus_stop, addr_valid, rx_valid, tx_ack_edge;
    logic addr_ack, conv_start, high_speed, sequencer_active;
    logic [7:0] addr_byte, rx_byte, tx_byte, status_reg;
    logic [6:0] target_addr;
    logic [2:0] mux_channel, c;
    logic [7:0] q [4];
    int err_count = 0;
    int checks_done = 0;
    adc_i2c_command_sequencer u_dut (
        .clk, .rst_n, .addr_strap, .bus_start, .bus_stop, .addr_valid,
        .addr_byte, .rx_valid, .rx_byte, .tx_ack_edge, .conv_done,
        .addr_ack, .tx_byte, .target_addr, .conv_start, .mux_channel,
        .status_reg, .high_speed, .sequencer_active
    );
    host_model #(.DEV(7'h15)) u_host (
        .clk, .addr_ack, .conv_start, .tx_byte, .bus_start, .bus_stop,
        .addr_valid, .addr_byte, .rx_valid, .rx_byte, .tx_ack_edge
    );
    // Free-running 40 MHz clock.
    always #12.5 clk = ~clk;
    // Counts a compare and reports a mismatch.
    task automatic chk(input logic [7:0] got, exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Next enabled channel for enables 0Ah, wrapping upward.
    function automatic logic [2:0] nxt(input logic [2:0] ch);
        return (ch == 3'h1 || ch == 3'h2) ? 3'h3 : 3'h1;
    endfunction
    // Single register write.
    task automatic wr(input logic [7:0] ra, d);
        u_host.cmd(`OP_WR_SINGLE, ra, d, 1);
    endtask
    // Points at ra, then reads n bytes in a fresh frame.
    task automatic rd(input logic [7:0] ra, input int n, input bit blk);
        u_host.cmd(blk ? `OP_RD_BLOCK : `OP_RD_SINGLE, ra, 8'h00, 0);
        u_host.rd_open();
        for (int i = 0; i < n; i++) u_host.rd_byte(q[i]);
        u_host.ev(1, 8'h00);
    endtask
    // One conversion-finished pulse, then room for the mux to move.
    task automatic done_pulse();
        @(posedge clk);
        conv_done <= 1'b1;
        @(posedge clk);
        conv_done <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_bus();
        logic [7:0] a [7] = '{8'h00, 8'h66, 8'h2a, 8'h09, 8'h0b, 8'h0d,
            8'h0f};
        chk(status_reg, 8'h81);
        chk(target_addr, 7'h15);
        chk(sequencer_active, 1'b0);
        for (int i = 0; i < 7; i++) begin
            u_host.ev(0, 8'h00);
            u_host.ev(2, a[i]);
            chk(u_host.got_ack, i < 3 && i != 1);
            chk(high_speed, i > 2);
            @(posedge clk);
            #1;
            chk(status_reg[5], i > 2);
            u_host.ev(1, 8'h00);
            chk(high_speed, 1'b0);
        end
        $display("test bus done");
    endtask
    task automatic t_regs();
        logic [7:0] e [4] = '{8'h02, 8'h03, 8'h00, 8'h00};
        rd(8'h04, 1, 0);
        chk(q[0], 8'h00);
        wr(8'h11, 8'h05);
        chk(mux_channel, 3'h5);
        rd(8'h11, 3, 0);
        for (int i = 0; i < 3; i++) chk(q[i], 8'h05);
        wr(8'h05, 8'h77);
        rd(8'h05, 1, 0);
        chk(q[0], 8'h00);
        u_host.cmd(`OP_WR_BLOCK, 8'h11, 8'h02, 3);
        u_host.cmd(`OP_WR_BLOCK, 8'hfe, 8'h40, 4);
        rd(8'h11, 4, 1);
        for (int i = 0; i < 4; i++) chk(q[i], e[i]);
        u_host.cmd(`OP_SET_BITS, 8'h12, 8'hf0, 1);
        rd(8'h12, 1, 0);
        chk(q[0], 8'hf3);
        u_host.cmd(`OP_CLR_BITS, 8'h12, 8'h21, 1);
        rd(8'h12, 1, 0);
        chk(q[0], 8'hd2);
        $display("test regs done");
    endtask
    task automatic t_conv();
        wr(8'h11, 8'h03);
        u_host.rd_open();
        u_host.rd_byte(q[0]);
        chk(u_host.got_conv, 1'b0);
        u_host.rd_byte(q[1]);
        chk(u_host.got_conv, 1'b1);
        u_host.ev(1, 8'h00);
        wr(8'h12, 8'h0a);
        wr(8'h04, 8'h01);
        wr(8'h10, 8'h10);
        chk(sequencer_active, 1'b1);
        chk(status_reg[6], 1'b1);
        repeat (3) begin
            c = nxt(mux_channel);
            done_pulse();
            chk(mux_channel, c);
        end
        wr(8'h10, 8'h00);
        chk(sequencer_active, 1'b0);
        chk(status_reg[6], 1'b0);
        c = mux_channel;
        done_pulse();
        chk(mux_channel, c);
        wr(8'h04, 8'h00);
        chk(mux_channel, 3'h3);
        $display("test conv done");
    endtask
    task automatic t_reset();
        wr(8'h00, 8'h01);
        chk(status_reg[0], 1'b0);
        wr(8'h11, 8'h06);
        wr(8'h01, 8'h01);
        rd(8'h11, 1, 0);
        chk(q[0], 8'h00);
        wr(8'h11, 8'h06);
        u_host.ev(0, 8'h00);
        u_host.ev(2, 8'h00);
        u_host.ev(3, `GC_RESET);
        u_host.ev(1, 8'h00);
        rd(8'h11, 1, 0);
        chk(q[0], 8'h00);
        u_host.cmd(`OP_SET_BITS, 8'h00, 8'h08, 1);
        chk(status_reg[0], 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(status_reg, 8'h81);
        $display("test reset done");
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Reset for three clocks, then the scenarios in turn.
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        t_bus();
        t_regs();
        t_conv();
        t_reset();
        test_done();
    end
endmodule
`default_nettype wire
